// ---- power_mode_pkg.sv ----
/*
 * Shared constants and carrier types for the power-mode and trip control.
 * Assumes a 10 MHz clock and byte-wide register access from the SMBus
 * protocol engine.
 */
package power_mode_pkg;

   // ****************************************
   // Register offsets and fields
   // ****************************************
   localparam int TRIP_COUNT = 5;
   localparam int TRIP_HIGH = 0;
   localparam int TRIP_LOW = 1;
   localparam int TRIP_PACK = 2;
   localparam int TRIP_CELL = 3;
   localparam int TRIP_STORE = 4;
   localparam logic [TRIP_COUNT-1:0][7:0] TRIP_OFS =
      {8'h70, 8'h6c, 8'h68, 8'h64, 8'h60};
   localparam logic [7:0] OFS_ACC_CLEAR = 8'h62;
   localparam logic [7:0] OFS_TRIP_ENABLE = 8'h76;
   localparam logic [7:0] OFS_OP_MODE = 8'h7a;
   localparam int MAG_MSB = 14;
   localparam int TE_HIGH_EXIT = 7;
   localparam int TE_LOW_ENTRY = 6;
   localparam int TE_PACK_EXIT = 5;
   localparam int TE_CELL1_ENTRY = 4;
   localparam int TE_CELL2_ENTRY = 3;
   localparam int TE_STORE_ENTRY = 2;
   localparam int TE_RANGE_FLAG = 0;
   localparam int OM_SLEEP = 7;
   localparam int OM_DIV_LSB = 3;
   localparam int OM_DIV_MSB = 5;
   localparam int OM_SHELF = 2;
   localparam int OM_POR = 1;
   localparam int OM_RELOAD = 0;
   localparam logic [15:0] TRIP_VALUE_RESET = 16'h0000;
   localparam logic [7:0] TRIP_ENABLE_RESET = 8'h00;
   localparam logic [2:0] DIVIDER_RESET = 3'h0;

   // ****************************************
   // Conversion channels and initialization map
   // ****************************************
   localparam logic [2:0] CH_CURRENT = 3'h0;
   localparam logic [2:0] CH_PACK = 3'h3;
   localparam logic [2:0] CH_CELL1 = 3'h4;
   localparam logic [2:0] CH_CELL2 = 3'h5;
   localparam logic [8:0] EE_INIT_FIRST = 9'h020;
   localparam logic [8:0] EE_WORK_LAST = 9'h07f;
   localparam logic [8:0] EE_INIT_LAST = 9'h084;
   localparam logic [1:0] BANK_WORK = 2'h1;
   localparam logic [1:0] BANK_CAL = 2'h2;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int HALF_SECOND_NS = 500000000;
   localparam int HALF_SECOND_CYCLES = HALF_SECOND_NS / CLK_PERIOD_NS;

   // ****************************************
   // Carrier types and states
   // ****************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_req_s;
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      logic [15:0] value;
      logic over_range;
   } adc_result_s;
   typedef struct packed {
      logic valid;
      logic [1:0] bank;
      logic [7:0] addr;
      logic [7:0] data;
   } load_s;
   typedef enum logic [1:0] {
      LD_IDLE = 2'b00, LD_READ = 2'b01, LD_DONE = 2'b10
   } load_state_e;
   typedef enum logic [1:0] {
      SH_OFF = 2'b00, SH_ARMED = 2'b01, SH_STOP = 2'b10, SH_ENTER = 2'b11
   } shelf_state_e;
endpackage

// ---- trip_magnitude_compare.sv ----
/*
 * Magnitude comparator for one trip point against a conversion result.
 * Assumes both operands are left-justified sign-magnitude words.
 */
module trip_magnitude_compare
   import power_mode_pkg::*;
(
   // Operands
   input wire logic [15:0] result,
   input wire logic [15:0] trip,
   // Compare outcome
   output logic above,
   output logic below
);
   // The sign bit is dropped from both operands.
   assign above = result[MAG_MSB:0] > trip[MAG_MSB:0];
   assign below = result[MAG_MSB:0] < trip[MAG_MSB:0];
endmodule // trip_magnitude_compare

// ---- init_loader.sv ----
/*
 * Copies the EEPROM initialization area into working and calibration
 * registers after reset and on each soft reload.
 * Assumes the EEPROM answers a held read request with a one-cycle ack.
 */
module init_loader
   import power_mode_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Control
   input wire logic start,
   output logic busy,
   output logic done,
   // EEPROM read port
   output logic ee_rd_req,
   output logic [8:0] ee_rd_addr,
   input wire logic ee_rd_ack,
   input wire logic [7:0] ee_rd_data,
   // Register load path
   output load_s load
);
   load_state_e state;

   // Walk the initialization area; reset starts a copy at once.
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= LD_READ;
         ee_rd_addr <= EE_INIT_FIRST;
      end else begin
         unique case (state)
            LD_IDLE: if (start) begin
               state <= LD_READ;
               ee_rd_addr <= EE_INIT_FIRST;
            end
            LD_READ: if (ee_rd_ack) begin
               if (ee_rd_addr == EE_INIT_LAST) state <= LD_DONE;
               else ee_rd_addr <= ee_rd_addr + 9'h001;
            end
            LD_DONE: state <= LD_IDLE;
            default: state <= LD_IDLE;
         endcase
      end
   end

   // Each fetched byte goes one to one to its bank.
   always_ff @(posedge clk) begin
      if (srst) begin
         load <= '0;
      end else begin
         load.valid <= state == LD_READ && ee_rd_ack;
         load.bank <= (ee_rd_addr <= EE_WORK_LAST) ? BANK_WORK : BANK_CAL;
         load.addr <= ee_rd_addr[7:0];
         load.data <= ee_rd_data;
      end
   end

   assign ee_rd_req = state == LD_READ;
   assign busy = state != LD_IDLE;
   assign done = state == LD_DONE;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   chk_load_bank_map: assert property (load.valid |->
      (load.bank == BANK_WORK) == (load.addr <= EE_WORK_LAST[7:0]))
      else $error("load went to the wrong bank");
   chk_load_range: assert property (load.valid |->
      load.addr >= EE_INIT_FIRST[7:0] && load.addr <= EE_INIT_LAST[7:0])
      else $error("load outside the initialization area");
endmodule // init_loader

// ---- power_mode_trip_control.sv ----
/*
 * Power-mode, trip-point and initialization control of the battery monitor.
 * Assumes an SMBus protocol engine on the same clock delivers byte register
 * accesses and a Stop pulse; line levels and supply detect are raw pins.
 */
module power_mode_trip_control
   import power_mode_pkg::*;
#(
   parameter int HALF_SEC_CYCLES = HALF_SECOND_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Supply-reset detector, raw pin
   input wire logic supply_low,
   // Register access from the SMBus engine
   input wire reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   // SMBus line state
   input wire logic smbus_stop,
   input wire logic scl_pin,
   input wire logic sda_pin,
   // Conversion results
   input wire adc_result_s adc_result,
   input wire logic [2:0] sample_divider,
   // EEPROM read port
   output logic ee_rd_req,
   output logic [8:0] ee_rd_addr,
   input wire logic ee_rd_ack,
   input wire logic [7:0] ee_rd_data,
   // Load path to working registers kept elsewhere
   output load_s load_out,
   // Accumulator clear strobes
   output logic [7:0] acc_clear,
   // Mode outputs
   output logic run_mode,
   output logic init_busy,
   output logic sampled_sleep,
   output logic low_power_osc_en,
   output logic sample_tick,
   output logic shelf_sleep_enter
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic rst;
   logic load_done;
   logic reload_pulse;
   logic host_wr;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [15:0] trip_val [TRIP_COUNT];
   logic [TRIP_COUNT-1:0] above;
   logic [TRIP_COUNT-1:0] below;
   logic [7:2] trip_en;
   logic range_flag;
   logic [2:0] sleep_interval_divider;
   logic por_flag;
   logic shelf_req;
   shelf_state_e shelf_state;
   logic res_cur;
   logic res_pack;
   logic exit_ev;
   logic entry_ev;
   logic shelf_ev;
   logic wr_operating_mode_control;
   logic [7:0] next_rdata;
   logic [$clog2(HALF_SEC_CYCLES)-1:0] half_cnt;
   logic half_tick;
   logic [15:0] interval_cnt;
   logic [15:0] interval_last;
   logic [3:0] interval_exp;

   // ****************************************
   // Pin synchronisers and internal reset
   // ****************************************
   // Supply detect, SCL and SDA cross in through two flip-flops each.
   always_ff @(posedge clk) begin
      pin_meta <= {supply_low, scl_pin, sda_pin};
      pin_sync <= pin_meta;
   end

   // The block is held in reset while the supply is below threshold.
   assign rst = srst | pin_sync[2];

   // ****************************************
   // Initialization loader
   // ****************************************
   init_loader u_loader (
      .clk(clk),
      .srst(rst),
      .start(reload_pulse),
      .busy(init_busy),
      .done(load_done),
      .ee_rd_req(ee_rd_req),
      .ee_rd_addr(ee_rd_addr),
      .ee_rd_ack(ee_rd_ack),
      .ee_rd_data(ee_rd_data),
      .load(load_out)
   );

   // Run mode follows completion of the copy and ends on a reload.
   always_ff @(posedge clk) begin
      if (rst) run_mode <= 1'b0;
      else if (reload_pulse) run_mode <= 1'b0;
      else if (load_done) run_mode <= 1'b1;
   end

   // ****************************************
   // Register write source
   // ****************************************
   // Loader bytes for bank 1 win; host writes are refused while loading.
   assign host_wr = reg_req.wr & ~init_busy;
   assign wr_en = load_out.valid ? (load_out.bank == BANK_WORK) : host_wr;
   assign wr_addr = load_out.valid ? load_out.addr : reg_req.addr;
   assign wr_data = load_out.valid ? load_out.data : reg_req.data;
   assign wr_operating_mode_control = wr_en && wr_addr == OFS_OP_MODE;

   // ****************************************
   // Trip values and comparators
   // ****************************************
   for (genvar i = 0; i < TRIP_COUNT; i++) begin : g_trip
      // Low byte at the offset, high byte just above it.
      always_ff @(posedge clk) begin
         if (rst) begin
            trip_val[i] <= TRIP_VALUE_RESET;
         end else if (wr_en && wr_addr == TRIP_OFS[i]) begin
            trip_val[i][7:0] <= wr_data;
         end else if (wr_en && wr_addr == TRIP_OFS[i] + 8'h01) begin
            trip_val[i][15:8] <= wr_data;
         end
      end

      trip_magnitude_compare u_cmp (
         .result(adc_result.value),
         .trip(trip_val[i]),
         .above(above[i]),
         .below(below[i])
      );
   end

   // Events fire on each fresh result for the compared channel.
   assign res_cur = adc_result.valid && adc_result.chan == CH_CURRENT;
   assign res_pack = adc_result.valid && adc_result.chan == CH_PACK;
   assign exit_ev = (res_cur && trip_en[TE_HIGH_EXIT] && above[TRIP_HIGH])
      || (res_pack && trip_en[TE_PACK_EXIT] && above[TRIP_PACK]);
   assign entry_ev = (res_cur && trip_en[TE_LOW_ENTRY] && below[TRIP_LOW])
      || (adc_result.valid && adc_result.chan == CH_CELL1
         && trip_en[TE_CELL1_ENTRY] && below[TRIP_CELL])
      || (adc_result.valid && adc_result.chan == CH_CELL2
         && trip_en[TE_CELL2_ENTRY] && below[TRIP_CELL]);
   assign shelf_ev = res_pack && trip_en[TE_STORE_ENTRY]
      && below[TRIP_STORE];

   // ****************************************
   // Trip enable register and range flag
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) trip_en <= TRIP_ENABLE_RESET[7:2];
      else if (wr_en && wr_addr == OFS_TRIP_ENABLE) trip_en <= wr_data[7:2];
   end

   // Hardware setting of the range flag wins over a clear.
   always_ff @(posedge clk) begin
      if (rst) range_flag <= TRIP_ENABLE_RESET[TE_RANGE_FLAG];
      else if (adc_result.valid && adc_result.over_range) range_flag <= 1'b1;
      else if (wr_en && wr_addr == OFS_TRIP_ENABLE) range_flag <= wr_data[TE_RANGE_FLAG];
   end

   // ****************************************
   // Accumulator clear
   // ****************************************
   // A written pattern strobes for one cycle, then the register clears.
   always_ff @(posedge clk) begin
      if (rst) acc_clear <= 8'h00;
      else if (wr_en && wr_addr == OFS_ACC_CLEAR) acc_clear <= wr_data;
      else acc_clear <= 8'h00;
   end

   // ****************************************
   // Operating mode register
   // ****************************************
   // Trip exit beats trip entry, and both beat a host write.
   always_ff @(posedge clk) begin
      if (rst) sampled_sleep <= 1'b0;
      else if (exit_ev) sampled_sleep <= 1'b0;
      else if (entry_ev) sampled_sleep <= 1'b1;
      else if (wr_operating_mode_control) sampled_sleep <= wr_data[OM_SLEEP];
   end

   assign low_power_osc_en = sampled_sleep;

   // Sample-Sleep interval divider.
   always_ff @(posedge clk) begin
      if (rst) sleep_interval_divider <= DIVIDER_RESET;
      else if (wr_operating_mode_control) sleep_interval_divider <= wr_data[OM_DIV_MSB:OM_DIV_LSB];
   end

   // Power-on flag: set by reset, cleared only by a host write of zero.
   always_ff @(posedge clk) begin
      if (rst) por_flag <= 1'b1;
      else if (host_wr && wr_addr == OFS_OP_MODE && !wr_data[OM_POR]) por_flag <= 1'b0;
   end

   // Soft reload is a host-only strobe that reads back as zero.
   always_ff @(posedge clk) begin
      if (rst) reload_pulse <= 1'b0;
      else reload_pulse <= host_wr && wr_addr == OFS_OP_MODE && wr_data[OM_RELOAD];
   end

   // A host write or the storage trip arms Shelf-Sleep; bytes from the loader never do.
   assign shelf_req = (host_wr && wr_addr == OFS_OP_MODE
      && wr_data[OM_SHELF]) || shelf_ev;

   // ****************************************
   // Shelf-Sleep sequencing
   // ****************************************
   // Armed, then a Stop, then both lines low before entry.
   always_ff @(posedge clk) begin
      if (rst) begin
         shelf_state <= SH_OFF;
      end else begin
         unique case (shelf_state)
            SH_OFF: if (shelf_req) shelf_state <= SH_ARMED;
            SH_ARMED: if (smbus_stop) shelf_state <= SH_STOP;
            SH_STOP: if (!pin_sync[1] && !pin_sync[0]) shelf_state <= SH_ENTER;
            SH_ENTER: shelf_state <= SH_ENTER;
         endcase
      end
   end

   assign shelf_sleep_enter = shelf_state == SH_ENTER;

   // ****************************************
   // Sample-Sleep interval timer
   // ****************************************
   // Half-second base enable, then two to the combined exponent of them.
   assign interval_exp = {1'b0, sample_divider} + {1'b0, sleep_interval_divider};
   assign interval_last = 16'((32'h1 << interval_exp) - 32'h1);
   assign half_tick = half_cnt == ($clog2(HALF_SEC_CYCLES))'(HALF_SEC_CYCLES - 1);

   always_ff @(posedge clk) begin
      if (rst || !sampled_sleep) half_cnt <= '0;
      else if (half_tick) half_cnt <= '0;
      else half_cnt <= half_cnt + 1'b1;
   end

   // Counts half seconds and pulses once per interval.
   always_ff @(posedge clk) begin
      if (rst || !sampled_sleep) begin
         interval_cnt <= 16'h0000;
         sample_tick <= 1'b0;
      end else begin
         sample_tick <= half_tick && interval_cnt >= interval_last;
         if (half_tick) begin
            if (interval_cnt >= interval_last) interval_cnt <= 16'h0000;
            else interval_cnt <= interval_cnt + 16'h0001;
         end
      end
   end

   // ****************************************
   // Register read
   // ****************************************
   // Unmapped addresses read as zero; reserved bits read as zero.
   always_comb begin
      next_rdata = 8'h00;
      for (int i = 0; i < TRIP_COUNT; i++) begin
         if (reg_req.addr == TRIP_OFS[i]) next_rdata = trip_val[i][7:0];
         if (reg_req.addr == TRIP_OFS[i] + 8'h01) next_rdata = trip_val[i][15:8];
      end
      if (reg_req.addr == OFS_ACC_CLEAR) next_rdata = acc_clear;
      if (reg_req.addr == OFS_TRIP_ENABLE) next_rdata = {trip_en, 1'b0, range_flag};
      if (reg_req.addr == OFS_OP_MODE) begin
         next_rdata = {sampled_sleep, 1'b0, sleep_interval_divider,
            shelf_state != SH_OFF, por_flag, 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) reg_rdata <= 8'h00;
      else if (reg_req.rd) reg_rdata <= next_rdata;
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_acc_clear_pulse: assert property (
      host_wr && !load_out.valid && reg_req.addr == OFS_ACC_CLEAR
      |=> acc_clear == $past(reg_req.data) ##1 acc_clear == 8'h00)
      else $error("accumulator clear did not strobe once");
   chk_high_exit: assert property (
      res_cur && trip_en[TE_HIGH_EXIT] && adc_result.value[14:0]
      > trip_val[TRIP_HIGH][14:0] |=> !sampled_sleep)
      else $error("high current did not leave Sample-Sleep");
   chk_low_entry: assert property (
      res_cur && trip_en[TE_LOW_ENTRY] && !trip_en[TE_HIGH_EXIT]
      && adc_result.value[14:0] < trip_val[TRIP_LOW][14:0]
      |=> sampled_sleep && low_power_osc_en)
      else $error("low current did not enter Sample-Sleep");
   chk_pack_exit: assert property (
      res_pack && trip_en[TE_PACK_EXIT] && adc_result.value[14:0]
      > trip_val[TRIP_PACK][14:0] |=> !sampled_sleep)
      else $error("pack voltage did not leave Sample-Sleep");
   chk_cell_entry: assert property (
      adc_result.valid && adc_result.chan == CH_CELL2
      && trip_en[TE_CELL2_ENTRY]
      && adc_result.value[14:0] < trip_val[TRIP_CELL][14:0]
      |=> sampled_sleep)
      else $error("cell voltage did not enter Sample-Sleep");
   chk_disabled_ignored: assert property (
      trip_en[7:3] == 5'h00 && !wr_operating_mode_control |=> $stable(sampled_sleep))
      else $error("disabled trip changed the mode");
   chk_storage_arm: assert property (
      shelf_state == SH_OFF && res_pack && trip_en[TE_STORE_ENTRY]
      && adc_result.value[14:0] < trip_val[TRIP_STORE][14:0]
      |=> shelf_state == SH_ARMED)
      else $error("storage threshold did not arm Shelf-Sleep");
   chk_range_flag: assert property (
      adc_result.valid && adc_result.over_range |=> range_flag)
      else $error("range flag not set");
   chk_host_sleep: assert property (
      wr_operating_mode_control && !exit_ev && !entry_ev |=> sampled_sleep == $past(wr_data[7]))
      else $error("Sample-Sleep bit did not follow the write");
   chk_shelf_order: assert property (
      $rose(shelf_sleep_enter) |-> $past(shelf_state) == SH_STOP
      && $past(pin_sync[1:0]) == 2'b00)
      else $error("Shelf-Sleep entered out of order");
   chk_por_hold: assert property (
      por_flag && !(host_wr && reg_req.addr == OFS_OP_MODE) |=> por_flag)
      else $error("power-on flag lost");
   chk_reload_start: assert property (
      reload_pulse |=> init_busy && !run_mode)
      else $error("soft reload did not start a copy");
   chk_run_after_init: assert property (
      load_done |=> run_mode)
      else $error("Run mode not entered after initialization");

   cov_trip_entry: cover property (entry_ev ##1 sampled_sleep);
   cov_trip_exit: cover property (sampled_sleep ##1 exit_ev);
   cov_shelf_entry: cover property ($rose(shelf_sleep_enter));
   cov_reload_done: cover property (reload_pulse ##[1:600] load_done);
endmodule // power_mode_trip_control

// ---- ee_model.sv ----
/* EEPROM read responder facing the initialization loader.
   Assumes the loader holds its request and address until the ack. */
module ee_model (
   // Clock
   input wire logic clk,
   // Read port
   input wire logic req,
   input wire logic [8:0] addr,
   output logic ack,
   output logic [7:0] data
);
   timeunit 1ns;
   timeprecision 1ns;
   int wait_n = 0;
   initial ack = 1'b0;
   initial data = 8'h00;
   // Answer after a random wait; data toggles when not acked.
   always @(posedge clk) begin
      ack <= 1'b0;
      data <= ~data;
      if (req && !ack) begin
         if (wait_n == 0) begin
            ack <= 1'b1;
            // Trip and mode bytes hold zero, as factory images do.
            data <= (addr >= 9'h060 && addr <= 9'h07f) ? 8'h00 :
               addr[7:0] ^ 8'h5a;
            wait_n = $urandom_range(2);
         end else wait_n--;
      end
   end
endmodule // ee_model

// ---- power_mode_trip_control_bench.sv ----
/* Self-checking bench for the power-mode and trip control.
   Assumes ee_model serves the EEPROM reads of the loader. */
module power_mode_trip_control_bench;
   import power_mode_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Signals and design
   // ****************************************
   logic clk, srst, supply_low, smbus_stop, scl_pin, sda_pin;
   logic ee_rd_req, ee_rd_ack, run_mode, init_busy, sampled_sleep;
   logic low_power_osc_en, sample_tick, shelf_sleep_enter;
   logic [7:0] reg_rdata, ee_rd_data, acc_clear, d, v;
   logic [8:0] ee_rd_addr;
   logic [2:0] sample_divider;
   reg_req_s reg_req;
   adc_result_s adc_result;
   load_s load_out;
   int fail_count = 0, samples_checked = 0, cyc = 0, n, exp_addr = 32;
   logic [7:0] t_en [6] = '{8'h40, 8'h80, 8'h00, 8'h10, 8'h20, 8'h08};
   logic [2:0] t_ch [6] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h3, 3'h5};
   logic [15:0] t_v [6] = '{16'hb000, 16'hf000, 16'h1000, 16'h4000,
      16'h6000, 16'h4000};
   int m_trip [5];
   bit m_sleep = 1'b0;
   power_mode_trip_control #(.HALF_SEC_CYCLES(4)) power_mode_trip_control_i (
      .clk, .srst, .supply_low, .reg_req, .reg_rdata, .smbus_stop, .scl_pin,
      .sda_pin, .adc_result, .sample_divider, .ee_rd_req, .ee_rd_addr,
      .ee_rd_ack, .ee_rd_data, .load_out, .acc_clear, .run_mode, .init_busy,
      .sampled_sleep, .low_power_osc_en, .sample_tick, .shelf_sleep_enter);
   ee_model ee_model_i (.clk, .req(ee_rd_req), .addr(ee_rd_addr),
      .ack(ee_rd_ack), .data(ee_rd_data));
   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   // Each loaded byte must match the next address of the copy plan.
   always @(posedge clk) if (load_out.valid) begin
      chk({load_out.bank, load_out.addr},
         {exp_addr > 127 ? 2'h2 : 2'h1, 8'(exp_addr)});
      chk(load_out.data, (exp_addr >= 96 && exp_addr <= 127) ? 8'h00 :
         8'(exp_addr) ^ 8'h5a);
      exp_addr = (exp_addr == 132) ? 32 : exp_addr + 1;
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] dt);
      @(negedge clk);
      reg_req = {1'b1, 1'b0, a, dt};
      @(negedge clk);
      reg_req.wr = 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(negedge clk);
      reg_req = {1'b0, 1'b1, a, 8'h00};
      @(negedge clk);
      reg_req.rd = 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   task wt(input int i, input logic [15:0] tv);
      m_trip[i] = tv[14:0];
      wr(TRIP_OFS[i], tv[7:0]);
      wr(TRIP_OFS[i] + 8'h1, tv[15:8]);
   endtask
   task res(input logic [2:0] ch, input logic [15:0] rv, input logic ov);
      @(negedge clk);
      adc_result = {1'b1, ch, rv, ov};
      @(negedge clk);
      adc_result.valid = 1'b0;
      @(negedge clk);
   endtask
   // Rule model of the trip-driven sleep bit; an exit beats an entry.
   task model_res(input logic [7:0] en, input logic [2:0] ch, input int mag);
      if ((en[7] && ch == CH_CURRENT && mag > m_trip[TRIP_HIGH]) ||
         (en[5] && ch == CH_PACK && mag > m_trip[TRIP_PACK])) m_sleep = 1'b0;
      else if ((en[6] && ch == CH_CURRENT && mag < m_trip[TRIP_LOW]) ||
         (en[4] && ch == CH_CELL1 && mag < m_trip[TRIP_CELL]) ||
         (en[3] && ch == CH_CELL2 && mag < m_trip[TRIP_CELL])) m_sleep = 1'b1;
   endtask
   task wait_run();
      for (n = 0; n < 500 && !run_mode; n++) @(negedge clk);
      chk(run_mode, 1'b1);
   endtask
   task results();
      $display("checks %0d failures %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      clk = 0; srst = 1; supply_low = 0; smbus_stop = 0; scl_pin = 1;
      sda_pin = 1; reg_req = '0; adc_result = '0; sample_divider = 3'h0;
      void'($urandom(87));
      repeat (4) @(negedge clk);
      srst = 0;
      wait_run();
      rd(OFS_OP_MODE);
      chk(d[OM_POR], 1'b1);
      wr(OFS_OP_MODE, 8'h00);
      rd(OFS_OP_MODE);
      chk(d, 8'h00);
      for (int i = 0; i < 2; i++) begin
         v = (i == 0) ? 8'h81 : 8'($urandom());
         wr(OFS_ACC_CLEAR, v);
         chk(acc_clear, v);
         @(negedge clk);
         chk(acc_clear, 8'h00);
      end
      rd(OFS_ACC_CLEAR);
      chk(d, 8'h00);
      wt(TRIP_HIGH, 16'h6000);
      wt(TRIP_LOW, 16'h4000);
      wt(TRIP_PACK, 16'h5000);
      wt(TRIP_CELL, 16'h5000);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_TRIP_ENABLE, t_en[i]);
         res(t_ch[i], t_v[i], 1'b0);
         model_res(t_en[i], t_ch[i], t_v[i][14:0]);
         chk(sampled_sleep, m_sleep);
      end
      wr(OFS_TRIP_ENABLE, 8'h00);
      res(CH_PACK, 16'h0000, 1'b1);
      rd(OFS_TRIP_ENABLE);
      chk(d, 8'h01);
      wr(OFS_OP_MODE, 8'h00);
      sample_divider = 3'h1;
      wr(OFS_OP_MODE, 8'h88);
      chk({sampled_sleep, low_power_osc_en}, 2'h3);
      for (n = 0; n < 99 && !sample_tick; n++) @(negedge clk);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!sample_tick && n < 99);
      chk(16'(n), 16'h10);
      wr(OFS_OP_MODE, 8'h00);
      chk(sampled_sleep, 1'b0);
      wr(OFS_OP_MODE, 8'h01);
      repeat (2) @(negedge clk);
      chk(run_mode, 1'b0);
      wait_run();
      rd(OFS_TRIP_ENABLE);
      chk(d, 8'h00);
      wt(TRIP_STORE, 16'h2000);
      wr(OFS_TRIP_ENABLE, 8'h04);
      res(CH_PACK, 16'h9000, 1'b0);
      rd(OFS_OP_MODE);
      chk(d, 8'h04);
      scl_pin = 0;
      sda_pin = 0;
      repeat (4) @(negedge clk);
      chk(shelf_sleep_enter, 1'b0);
      smbus_stop = 1;
      @(negedge clk);
      smbus_stop = 0;
      repeat (4) @(negedge clk);
      chk(shelf_sleep_enter, 1'b1);
      supply_low = 1;
      repeat (5) @(negedge clk);
      chk({run_mode, shelf_sleep_enter}, 2'h0);
      supply_low = 0;
      wait_run();
      rd(OFS_OP_MODE);
      chk(d, 8'h02);
      wr(OFS_OP_MODE, 8'h06);
      rd(OFS_OP_MODE);
      chk(d, 8'h06);
      results();
   end
endmodule // power_mode_trip_control_bench
